// File: common/sysclk_params.svh
`ifndef SYSCLK_PARAMS_SVH
`define SYSCLK_PARAMS_SVH

// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define OFS_STATUS 10'h000
`define OFS_UNLOCK 10'h004
`define OFS_SLOW_RC 10'h008
`define OFS_PLL 10'h00c
`define OFS_HIRES 10'h010
`define OFS_FRAC 10'h014
`define OFS_FRAC_MUL 10'h018
`define OFS_FRAC_DIV 10'h01c
`define OFS_GCLK_BASE 10'h040
`define OFS_BACKUP_BASE 10'h080

// ----------------------------------------
// unlock key
// ----------------------------------------
`define UNLOCK_KEY 8'haa
`define UNLOCK_KEY_MSB 31
`define UNLOCK_KEY_LSB 24
`define UNLOCK_ADDR_MSB 9

// ----------------------------------------
// field positions
// ----------------------------------------
`define SLOW_RC_EN_BIT 0
`define GCLK_DIV_MSB 31
`define GCLK_DIV_LSB 16
`define GCLK_SEL_MSB 12
`define GCLK_SEL_LSB 8
`define GCLK_DIVIDE_ENABLE_BIT 1
`define GCLK_CEN_BIT 0
`define PLL_COUNT_MSB 29
`define PLL_COUNT_LSB 24
`define PLL_MUL_MSB 19
`define PLL_MUL_LSB 16
`define PLL_DIV_MSB 11
`define PLL_DIV_LSB 8
`define PLL_OPT_MSB 6
`define PLL_OPT_LSB 4
`define PLL_OSC_MSB 2
`define PLL_OSC_LSB 1
`define PLL_EN_BIT 0
`define HR_COUNT_MSB 31
`define HR_COUNT_LSB 8
`define PS_SEL_MSB 3
`define PS_SEL_LSB 1
`define PS_EN_BIT 0
`define FRAC_FACTOR_MSB 15
`define STATUS_LOCK_BIT 0
`define STATUS_BACKUP_BIT 1

// ----------------------------------------
// reset values and timing
// ----------------------------------------
`define RESET_WORD 32'h00000000
`define BACKUP_BUSY_CYCLES 2'h2

`endif

// File: common/sysclk_pkg.sv
package sysclk_pkg;

	// ----------------------------------------
	// generic clock configuration
	// ----------------------------------------
	typedef struct packed {
		logic [15:0] div;
		logic [4:0] source_select;
		logic divide_enable;
		logic output_enable;
	} gclk_cfg_type;

	// ----------------------------------------
	// pll configuration
	// ----------------------------------------
	typedef struct packed {
		logic [5:0] lock_wait_count;
		logic [3:0] loop_multiply_factor;
		logic [3:0] loop_division_factor;
		logic [2:0] loop_option_bits;
		logic [1:0] loop_reference_select;
		logic loop_enable;
	} pll_cfg_type;

	// ----------------------------------------
	// prescaler configuration
	// ----------------------------------------
	typedef struct packed {
		logic [23:0] hires_period_count;
		logic [2:0] prescaler_input_select;
		logic enable;
	} prescaler_cfg_type;

endpackage : sysclk_pkg

// File: hw/backup_mem.sv
`timescale 1ns/10ps
// retained word store; contents change only on write or reset
module backup_mem #(
	parameter int WORDS = 4,
	parameter int AW = 2
) (
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	input wire logic clk_en,
	// write side
	input wire logic wr_en,
	input wire logic [AW-1:0] wr_addr,
	input wire logic [31:0] wr_data,
	// read side
	input wire logic rd_en,
	input wire logic [AW-1:0] rd_addr,
	output logic [31:0] rd_data
);

	logic [31:0] mem [WORDS];

	// ----------------------------------------
	// storage, untouched by shutdown
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (reset) begin
			for (int i = 0; i < WORDS; i++) begin
				mem[i] <= 32'h00000000;
			end
		end else if (clk_en && wr_en) begin
			mem[wr_addr] <= wr_data;
		end
	end

	// registered read port
	always_ff @(posedge clk) begin
		if (reset) begin
			rd_data <= 32'h00000000;
		end else if (clk_en && rd_en) begin
			rd_data <= mem[rd_addr];
		end
	end

endmodule : backup_mem

// File: hw/system_clock_config_regs.sv
`timescale 1ns/10ps
`include "sysclk_params.svh"
module system_clock_config_regs
	import sysclk_pkg::*;
#(
	parameter int NUM_GCLK = 4,
	parameter int GCLK_DIV_BITS = 16,
	parameter int NUM_BACKUP = 4,
	parameter int NUM_SRC = 32
) (
	// clock, reset, enable
	input wire logic clk,
	input wire logic reset,
	input wire logic clk_en,
	// register port
	input wire logic [9:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [31:0] rdata,
	// clock sources and events
	input wire logic [NUM_SRC-1:0] src_tick,
	input wire logic system_rc_clock,
	input wire logic pll_wake,
	// oscillator and pll controls
	output logic slow_rc_enable,
	output pll_cfg_type pll_cfg,
	output logic pll_locked_flag,
	output logic [5:0] pll_ratio_num,
	output logic [3:0] pll_ratio_den,
	output logic pll_range_high,
	output logic pll_out_half,
	output logic pll_wide_bw,
	// generic clocks
	output gclk_cfg_type [NUM_GCLK-1:0] gclk_cfg,
	output logic [NUM_GCLK-1:0] gclk_tick,
	// prescalers and backup busy flag
	output logic hires_prescaled_clock,
	output logic frac_prescaled_clock,
	output logic backup_iface_ready_flag
);

	// ----------------------------------------
	// decode
	// ----------------------------------------
	localparam int BAW = $clog2(NUM_BACKUP);
	localparam logic [15:0] DIV_MASK = 16'((32'h1 << GCLK_DIV_BITS) - 32'h1);
	localparam logic [9:0] GCLK_END = 10'(`OFS_GCLK_BASE + 4 * NUM_GCLK);
	localparam logic [9:0] BACKUP_END = 10'(`OFS_BACKUP_BASE + 4 * NUM_BACKUP);

	logic armed;
	logic [9:0] unlock_target;
	logic key_ok;
	logic wr_go;
	logic rd_go;
	logic in_gclk;
	logic in_backup;
	logic [7:0] gclk_idx;
	logic [BAW-1:0] backup_idx;
	logic pll_wr_ok;
	logic backup_wr_ok;
	logic [1:0] backup_busy;
	logic [5:0] lock_cnt;
	prescaler_cfg_type hires_cfg;
	prescaler_cfg_type frac_cfg;
	logic [15:0] frac_mul;
	logic [15:0] frac_div;
	logic [23:0] hires_cnt;
	logic [15:0] frac_acc;
	logic [16:0] frac_sum;
	logic [31:0] next_rdata;
	logic [31:0] reg_rdata;
	logic mem_sel;
	logic [31:0] mem_rdata;

	// bus qualifiers
	assign wr_go = clk_en && wr;
	assign rd_go = clk_en && rd;
	assign in_gclk = (addr >= `OFS_GCLK_BASE) && (addr < GCLK_END) && (addr[1:0] == 2'h0);
	assign in_backup = (addr >= `OFS_BACKUP_BASE) && (addr < BACKUP_END) && (addr[1:0] == 2'h0);
	assign gclk_idx = 8'((addr - `OFS_GCLK_BASE) >> 2);
	assign backup_idx = BAW'((addr - `OFS_BACKUP_BASE) >> 2);
	assign key_ok = armed && (addr == unlock_target);
	assign pll_wr_ok = wr_go && (addr == `OFS_PLL) && key_ok && !pll_cfg.loop_enable;
	assign backup_wr_ok = wr_go && in_backup && key_ok;

	// ----------------------------------------
	// unlock key
	// ----------------------------------------
	// key arms exactly the next write, for one named offset
	always_ff @(posedge clk) begin
		if (reset) begin
			armed <= 1'b0;
			unlock_target <= 10'h000;
		end else if (wr_go) begin
			if (addr == `OFS_UNLOCK) begin
				armed <= (wdata[`UNLOCK_KEY_MSB:`UNLOCK_KEY_LSB] == `UNLOCK_KEY);
				unlock_target <= wdata[`UNLOCK_ADDR_MSB:0];
			end else begin
				armed <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// slow rc oscillator and pll registers
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (reset) begin
			slow_rc_enable <= 1'b0;
		end else if (wr_go && (addr == `OFS_SLOW_RC) && key_ok) begin
			slow_rc_enable <= wdata[`SLOW_RC_EN_BIT];
		end
	end

	// pll configuration, frozen while running
	always_ff @(posedge clk) begin
		if (reset) begin
			pll_cfg <= '0;
		end else if (pll_wr_ok) begin
			pll_cfg.lock_wait_count <= wdata[`PLL_COUNT_MSB:`PLL_COUNT_LSB];
			pll_cfg.loop_multiply_factor <= wdata[`PLL_MUL_MSB:`PLL_MUL_LSB];
			pll_cfg.loop_division_factor <= wdata[`PLL_DIV_MSB:`PLL_DIV_LSB];
			pll_cfg.loop_option_bits <= wdata[`PLL_OPT_MSB:`PLL_OPT_LSB];
			pll_cfg.loop_reference_select <= wdata[`PLL_OSC_MSB:`PLL_OSC_LSB];
			pll_cfg.loop_enable <= wdata[`PLL_EN_BIT];
		end
	end

	// derived pll ratio and option outputs
	always_ff @(posedge clk) begin
		if (reset) begin
			pll_ratio_num <= 6'h00;
			pll_ratio_den <= 4'h0;
			pll_range_high <= 1'b0;
			pll_out_half <= 1'b0;
			pll_wide_bw <= 1'b1;
		end else if (clk_en) begin
			if (pll_cfg.loop_division_factor == 4'h0) begin
				// 2*(mul+1) reaches 32, hence the sixth bit
				pll_ratio_num <= {1'b0, pll_cfg.loop_multiply_factor, 1'b0} + 6'h02;
				pll_ratio_den <= 4'h1;
			end else begin
				pll_ratio_num <= {2'b00, pll_cfg.loop_multiply_factor} + 6'h01;
				pll_ratio_den <= pll_cfg.loop_division_factor;
			end
			pll_range_high <= pll_cfg.loop_option_bits[0];
			pll_out_half <= pll_cfg.loop_option_bits[1];
			pll_wide_bw <= !pll_cfg.loop_option_bits[2];
		end
	end

	// ----------------------------------------
	// pll lock timing
	// ----------------------------------------
	// rc ticks counted from write or wake; any restart drops lock
	always_ff @(posedge clk) begin
		if (reset) begin
			lock_cnt <= 6'h00;
			pll_locked_flag <= 1'b0;
		end else if (clk_en) begin
			if (pll_wr_ok || pll_wake || !pll_cfg.loop_enable) begin
				lock_cnt <= 6'h00;
				pll_locked_flag <= 1'b0;
			end else if (lock_cnt == pll_cfg.lock_wait_count) begin
				pll_locked_flag <= 1'b1;
			end else if (system_rc_clock) begin
				lock_cnt <= lock_cnt + 6'h01;
			end
		end
	end

	// ----------------------------------------
	// generic clocks
	// ----------------------------------------
	for (genvar g = 0; g < NUM_GCLK; g++) begin : gen_gclk
		logic [16:0] div_cnt;

		// one independent control word per generic clock
		always_ff @(posedge clk) begin
			if (reset) begin
				gclk_cfg[g] <= '0;
			end else if (wr_go && in_gclk && (gclk_idx == 8'(g))) begin
				gclk_cfg[g].div <= wdata[`GCLK_DIV_MSB:`GCLK_DIV_LSB] & DIV_MASK;
				gclk_cfg[g].source_select <= wdata[`GCLK_SEL_MSB:`GCLK_SEL_LSB];
				gclk_cfg[g].divide_enable <= wdata[`GCLK_DIVIDE_ENABLE_BIT];
				gclk_cfg[g].output_enable <= wdata[`GCLK_CEN_BIT];
			end
		end

		// divider on the selected source tick
		always_ff @(posedge clk) begin
			if (reset) begin
				div_cnt <= 17'h00000;
				gclk_tick[g] <= 1'b0;
			end else if (clk_en) begin
				gclk_tick[g] <= 1'b0;
				if (!gclk_cfg[g].output_enable) begin
					div_cnt <= 17'h00000;
				end else if (src_tick[gclk_cfg[g].source_select]) begin
					if (!gclk_cfg[g].divide_enable) begin
						gclk_tick[g] <= 1'b1;
					end else if (div_cnt == {gclk_cfg[g].div, 1'b1}) begin
						gclk_tick[g] <= 1'b1;
						div_cnt <= 17'h00000;
					end else begin
						div_cnt <= div_cnt + 17'h00001;
					end
				end
			end
		end
	end

	// ----------------------------------------
	// prescaler registers
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (reset) begin
			hires_cfg <= '0;
			frac_cfg <= '0;
			frac_mul <= 16'h0000;
			frac_div <= 16'h0000;
		end else if (wr_go) begin
			if (addr == `OFS_HIRES) begin
				hires_cfg.hires_period_count <= wdata[`HR_COUNT_MSB:`HR_COUNT_LSB];
				hires_cfg.prescaler_input_select <= wdata[`PS_SEL_MSB:`PS_SEL_LSB];
				hires_cfg.enable <= wdata[`PS_EN_BIT];
			end else if (addr == `OFS_FRAC) begin
				frac_cfg.prescaler_input_select <= wdata[`PS_SEL_MSB:`PS_SEL_LSB];
				frac_cfg.enable <= wdata[`PS_EN_BIT];
			end else if (addr == `OFS_FRAC_MUL) begin
				frac_mul <= wdata[`FRAC_FACTOR_MSB:0];
			end else if (addr == `OFS_FRAC_DIV) begin
				frac_div <= wdata[`FRAC_FACTOR_MSB:0];
			end
		end
	end

	// high resolution prescaler: toggle after count+1 input periods
	always_ff @(posedge clk) begin
		if (reset) begin
			hires_cnt <= 24'h000000;
			hires_prescaled_clock <= 1'b0;
		end else if (clk_en) begin
			if (!hires_cfg.enable) begin
				hires_cnt <= 24'h000000;
				hires_prescaled_clock <= 1'b0;
			end else if (src_tick[hires_cfg.prescaler_input_select]) begin
				if (hires_cnt >= hires_cfg.hires_period_count) begin
					hires_cnt <= 24'h000000;
					hires_prescaled_clock <= !hires_prescaled_clock;
				end else begin
					hires_cnt <= hires_cnt + 24'h000001;
				end
			end
		end
	end

	// fractional prescaler: accumulate mul, emit a pulse per div
	assign frac_sum = {1'b0, frac_acc} + {1'b0, frac_mul};

	always_ff @(posedge clk) begin
		if (reset) begin
			frac_acc <= 16'h0000;
			frac_prescaled_clock <= 1'b0;
		end else if (clk_en) begin
			frac_prescaled_clock <= 1'b0;
			if (!frac_cfg.enable) begin
				frac_acc <= 16'h0000;
			end else if (src_tick[frac_cfg.prescaler_input_select] && (frac_div != 16'h0000)) begin
				if (frac_sum >= {1'b0, frac_div}) begin
					frac_acc <= 16'(frac_sum - {1'b0, frac_div});
					frac_prescaled_clock <= 1'b1;
				end else begin
					frac_acc <= frac_sum[15:0];
				end
			end
		end
	end

	// ----------------------------------------
	// backup words
	// ----------------------------------------
	// busy window after each accepted backup write
	always_ff @(posedge clk) begin
		if (reset) begin
			backup_busy <= 2'h0;
			backup_iface_ready_flag <= 1'b0;
		end else if (clk_en) begin
			if (backup_wr_ok) begin
				backup_busy <= `BACKUP_BUSY_CYCLES;
				backup_iface_ready_flag <= 1'b1;
			end else if (backup_busy != 2'h0) begin
				backup_busy <= backup_busy - 2'h1;
				backup_iface_ready_flag <= (backup_busy != 2'h1);
			end
		end
	end

	backup_mem #(
		.WORDS(NUM_BACKUP),
		.AW(BAW)
	) u_backup (
		.clk(clk),
		.reset(reset),
		.clk_en(clk_en),
		.wr_en(backup_wr_ok),
		.wr_addr(backup_idx),
		.wr_data(wdata),
		.rd_en(rd && in_backup),
		.rd_addr(backup_idx),
		.rd_data(mem_rdata)
	);

	// ----------------------------------------
	// read path
	// ----------------------------------------
	always_comb begin
		next_rdata = `RESET_WORD;
		if (addr == `OFS_STATUS) begin
			next_rdata[`STATUS_LOCK_BIT] = pll_locked_flag;
			next_rdata[`STATUS_BACKUP_BIT] = backup_iface_ready_flag;
		end else if (addr == `OFS_SLOW_RC) begin
			next_rdata[`SLOW_RC_EN_BIT] = slow_rc_enable;
		end else if (addr == `OFS_PLL) begin
			next_rdata[`PLL_COUNT_MSB:`PLL_COUNT_LSB] = pll_cfg.lock_wait_count;
			next_rdata[`PLL_MUL_MSB:`PLL_MUL_LSB] = pll_cfg.loop_multiply_factor;
			next_rdata[`PLL_DIV_MSB:`PLL_DIV_LSB] = pll_cfg.loop_division_factor;
			next_rdata[`PLL_OPT_MSB:`PLL_OPT_LSB] = pll_cfg.loop_option_bits;
			next_rdata[`PLL_OSC_MSB:`PLL_OSC_LSB] = pll_cfg.loop_reference_select;
			next_rdata[`PLL_EN_BIT] = pll_cfg.loop_enable;
		end else if (addr == `OFS_HIRES) begin
			next_rdata[`HR_COUNT_MSB:`HR_COUNT_LSB] = hires_cfg.hires_period_count;
			next_rdata[`PS_SEL_MSB:`PS_SEL_LSB] = hires_cfg.prescaler_input_select;
			next_rdata[`PS_EN_BIT] = hires_cfg.enable;
		end else if (addr == `OFS_FRAC) begin
			next_rdata[`PS_SEL_MSB:`PS_SEL_LSB] = frac_cfg.prescaler_input_select;
			next_rdata[`PS_EN_BIT] = frac_cfg.enable;
		end else if (addr == `OFS_FRAC_MUL) begin
			next_rdata[`FRAC_FACTOR_MSB:0] = frac_mul;
		end else if (addr == `OFS_FRAC_DIV) begin
			next_rdata[`FRAC_FACTOR_MSB:0] = frac_div;
		end else if (in_gclk && (gclk_idx < 8'(NUM_GCLK))) begin
			next_rdata[`GCLK_DIV_MSB:`GCLK_DIV_LSB] = gclk_cfg[gclk_idx].div;
			next_rdata[`GCLK_SEL_MSB:`GCLK_SEL_LSB] = gclk_cfg[gclk_idx].source_select;
			next_rdata[`GCLK_DIVIDE_ENABLE_BIT] = gclk_cfg[gclk_idx].divide_enable;
			next_rdata[`GCLK_CEN_BIT] = gclk_cfg[gclk_idx].output_enable;
		end
	end

	// read data valid in the cycle after the strobe
	always_ff @(posedge clk) begin
		if (reset) begin
			reg_rdata <= `RESET_WORD;
			mem_sel <= 1'b0;
		end else if (clk_en) begin
			reg_rdata <= rd_go ? next_rdata : `RESET_WORD;
			mem_sel <= rd_go && in_backup;
		end
	end

	assign rdata = mem_sel ? mem_rdata : reg_rdata;

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	a_pll_write_gate: assert property (wr_go && addr == `OFS_PLL && pll_cfg.loop_enable |=> $stable(pll_cfg)) else $error("pll written while enabled");
	a_lock_drops: assert property (clk_en && !pll_cfg.loop_enable |=> !pll_locked_flag) else $error("lock held with pll off");
	a_key_needed: assert property (wr_go && addr == `OFS_SLOW_RC && !key_ok |=> $stable(slow_rc_enable)) else $error("unkeyed write took effect");
	a_keyed_rc: assert property (wr_go && addr == `OFS_SLOW_RC && key_ok |=> slow_rc_enable == $past(wdata[0])) else $error("keyed rc write lost");
	a_lock_timing: assert property ($rose(pll_locked_flag) |-> $past(lock_cnt) == pll_cfg.lock_wait_count) else $error("lock before count");
	a_gclk_stop: assert property (clk_en && !gclk_cfg[1].output_enable |=> !gclk_tick[1]) else $error("stopped clock ticked");
	a_gclk_bypass: assert property (clk_en && gclk_cfg[1].output_enable && !gclk_cfg[1].divide_enable && src_tick[gclk_cfg[1].source_select] |=> gclk_tick[1]) else $error("undivided tick lost");
	a_hires_off: assert property (clk_en && !hires_cfg.enable |=> !hires_prescaled_clock) else $error("hires runs disabled");
	a_frac_off: assert property (clk_en && !frac_cfg.enable |=> !frac_prescaled_clock) else $error("frac runs disabled");
	a_ratio_zero: assert property (clk_en && pll_cfg.loop_division_factor == 4'h0 |=> pll_ratio_den == 4'h1) else $error("ratio denominator wrong");

	c_pll_locks: cover property ($rose(pll_locked_flag));
	c_keyed_backup: cover property (backup_wr_ok);
	c_gclk_divided: cover property (gclk_cfg[1].divide_enable && gclk_tick[1]);
	c_frac_pulse: cover property (frac_prescaled_clock);

endmodule : system_clock_config_regs

// File: dv/tb_system_clock_config_regs.sv
`timescale 1ns/10ps
`include "sysclk_params.svh"
module tb_system_clock_config_regs;
	import sysclk_pkg::*;

	// ----------------------------------------
	// stimulus and observed signals
	// ----------------------------------------
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic clk_en = 1'b1;
	logic [9:0] addr = 10'h000;
	logic [31:0] wdata = 32'h00000000;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [31:0] rdata;
	logic [31:0] src_tick = 32'h00000000;
	logic system_rc_clock = 1'b0;
	logic pll_wake = 1'b0;
	logic slow_rc_enable, pll_locked_flag, pll_range_high, pll_out_half, pll_wide_bw;
	logic hires_prescaled_clock, frac_prescaled_clock, backup_iface_ready_flag;
	logic prev_h = 1'b0;
	logic [5:0] pll_ratio_num;
	logic [3:0] pll_ratio_den;
	logic [3:0] gclk_tick;
	pll_cfg_type pll_cfg;
	gclk_cfg_type [3:0] gclk_cfg;
	int err_total = 0;
	int check_count = 0;
	int n_g = 0;
	int n_f = 0;
	int n_h = 0;
	int base;

	system_clock_config_regs #(.NUM_GCLK(4), .GCLK_DIV_BITS(8), .NUM_BACKUP(4), .NUM_SRC(32)) i_dut (
		.clk(clk), .reset(reset), .clk_en(clk_en), .addr(addr), .wdata(wdata), .wr(wr),
		.rd(rd), .rdata(rdata), .src_tick(src_tick), .system_rc_clock(system_rc_clock),
		.pll_wake(pll_wake), .slow_rc_enable(slow_rc_enable), .pll_cfg(pll_cfg),
		.pll_locked_flag(pll_locked_flag), .pll_ratio_num(pll_ratio_num),
		.pll_ratio_den(pll_ratio_den), .pll_range_high(pll_range_high),
		.pll_out_half(pll_out_half), .pll_wide_bw(pll_wide_bw), .gclk_cfg(gclk_cfg),
		.gclk_tick(gclk_tick), .hires_prescaled_clock(hires_prescaled_clock),
		.frac_prescaled_clock(frac_prescaled_clock),
		.backup_iface_ready_flag(backup_iface_ready_flag)
	);

	// 50 ns clock
	initial begin
		forever #25 clk = ~clk;
	end

	// output event counters
	always @(posedge clk) begin
		if (gclk_tick[1] === 1'b1) n_g <= n_g + 1;
		if (frac_prescaled_clock === 1'b1) n_f <= n_f + 1;
		if (hires_prescaled_clock !== prev_h) n_h <= n_h + 1;
		prev_h <= hires_prescaled_clock;
	end

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			err_total++;
			$display("BAD %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	task automatic bus_write(input logic [9:0] a, input logic [31:0] d);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
	endtask : bus_write

	task automatic bus_read(input logic [9:0] a, output logic [31:0] d);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1 d = rdata;
	endtask : bus_read

	// key write directly ahead of the protected write
	task automatic key_write(input logic [9:0] a, input logic [31:0] d);
		bus_write(`OFS_UNLOCK, {`UNLOCK_KEY, 14'h0000, a});
		bus_write(a, d);
	endtask : key_write

	task automatic read_check(input string name, input logic [9:0] a, input logic [31:0] exp);
		logic [31:0] d;
		bus_read(a, d);
		check(name, d, exp);
	endtask : read_check

	// one-cycle pulses on a source, spaced by one idle cycle
	task automatic tick(input int idx, input int n);
		repeat (n) begin
			@(posedge clk);
			src_tick[idx] <= 1'b1;
			@(posedge clk);
			src_tick[idx] <= 1'b0;
		end
		repeat (4) @(posedge clk);
	endtask : tick

	task automatic rc_ticks(input int n);
		repeat (n) begin
			@(posedge clk);
			system_rc_clock <= 1'b1;
			@(posedge clk);
			system_rc_clock <= 1'b0;
		end
		repeat (2) @(posedge clk);
		#1;
	endtask : rc_ticks

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic test_reset_and_lock();
		read_check("slow_rc", `OFS_SLOW_RC, `RESET_WORD);
		read_check("pll", `OFS_PLL, `RESET_WORD);
		read_check("gclk0", `OFS_GCLK_BASE, `RESET_WORD);
		read_check("hires", `OFS_HIRES, `RESET_WORD);
		read_check("frac", `OFS_FRAC, `RESET_WORD);
		read_check("backup0", `OFS_BACKUP_BASE, `RESET_WORD);
		read_check("unmapped", 10'h3fc, `RESET_WORD);
		check("wide_bw", pll_wide_bw, 1'b1);
		bus_write(`OFS_SLOW_RC, 32'h00000001);
		read_check("slow_rc unkeyed", `OFS_SLOW_RC, `RESET_WORD);
		bus_write(`OFS_UNLOCK, {`UNLOCK_KEY, 14'h0000, `OFS_SLOW_RC});
		bus_write(`OFS_FRAC_MUL, 32'h00000002);
		bus_write(`OFS_SLOW_RC, 32'h00000001);
		read_check("slow_rc disarmed", `OFS_SLOW_RC, `RESET_WORD);
		key_write(`OFS_SLOW_RC, 32'h00000001);
		#1 check("slow_rc_enable", slow_rc_enable, 1'b1);
		read_check("slow_rc keyed", `OFS_SLOW_RC, 32'h00000001);
		@(posedge clk) clk_en <= 1'b0;
		bus_write(`OFS_FRAC_MUL, 32'h00000005);
		clk_en <= 1'b1;
		read_check("frozen write", `OFS_FRAC_MUL, 32'h00000002);
		$display("test reset_and_lock done");
	endtask : test_reset_and_lock

	task automatic test_backup();
		int w;
		key_write(`OFS_BACKUP_BASE + 10'h004, 32'hc3a5_5a3c);
		#1 check("busy", backup_iface_ready_flag, 1'b1);
		w = 0;
		while (backup_iface_ready_flag !== 1'b0 && w < 10) begin
			@(posedge clk);
			#1 w++;
		end
		check("busy cleared", backup_iface_ready_flag, 1'b0);
		bus_write(`OFS_BACKUP_BASE + 10'h008, 32'h11111111);
		read_check("backup1", `OFS_BACKUP_BASE + 10'h004, 32'hc3a55a3c);
		read_check("backup2 unkeyed", `OFS_BACKUP_BASE + 10'h008, `RESET_WORD);
		$display("test backup done");
	endtask : test_backup

	task automatic test_gclk();
		bus_write(`OFS_GCLK_BASE + 10'h004, 32'hff010303);
		read_check("gclk1 div bits", `OFS_GCLK_BASE + 10'h004, 32'h00010303);
		read_check("gclk0 alone", `OFS_GCLK_BASE, `RESET_WORD);
		check("gclk1 port", gclk_cfg[1], 32'h0000008f);
		base = n_g;
		tick(3, 16);
		check("gclk divided", n_g - base, 4);
		bus_write(`OFS_GCLK_BASE + 10'h004, 32'h00000301);
		base = n_g;
		tick(3, 5);
		tick(4, 3);
		check("gclk undivided", n_g - base, 5);
		bus_write(`OFS_GCLK_BASE + 10'h004, 32'h00000300);
		base = n_g;
		tick(3, 4);
		check("gclk stopped", n_g - base, 0);
		$display("test gclk done");
	endtask : test_gclk

	task automatic test_pll();
		key_write(`OFS_PLL, 32'h03050234);
		repeat (2) @(posedge clk);
		#1 check("ratio num", pll_ratio_num, 6'd6);
		check("ratio den", pll_ratio_den, 4'd2);
		check("range", pll_range_high, 1'b1);
		check("half", pll_out_half, 1'b1);
		check("wide on", pll_wide_bw, 1'b1);
		check("ref", pll_cfg.loop_reference_select, 2'd2);
		key_write(`OFS_PLL, 32'h03050074);
		repeat (2) @(posedge clk);
		#1 check("ratio num div0", pll_ratio_num, 6'd12);
		check("ratio den div0", pll_ratio_den, 4'd1);
		check("wide off", pll_wide_bw, 1'b0);
		key_write(`OFS_PLL, 32'h03050235);
		rc_ticks(2);
		check("not yet locked", pll_locked_flag, 1'b0);
		rc_ticks(1);
		check("locked", pll_locked_flag, 1'b1);
		read_check("status lock", `OFS_STATUS, 32'h00000001);
		key_write(`OFS_PLL, 32'h01000000);
		read_check("pll discard", `OFS_PLL, 32'h03050235);
		@(posedge clk) pll_wake <= 1'b1;
		@(posedge clk) pll_wake <= 1'b0;
		rc_ticks(2);
		check("wake restart", pll_locked_flag, 1'b0);
		rc_ticks(1);
		check("wake relock", pll_locked_flag, 1'b1);
		$display("test pll done");
	endtask : test_pll

	task automatic test_prescalers();
		bus_write(`OFS_HIRES, 32'h00000105);
		base = n_h;
		tick(2, 6);
		check("hires toggles", n_h - base, 3);
		check("hires high", hires_prescaled_clock, 1'b1);
		bus_write(`OFS_HIRES, 32'h00000104);
		repeat (2) @(posedge clk);
		#1 check("hires off", hires_prescaled_clock, 1'b0);
		bus_write(`OFS_FRAC_MUL, 32'h00000001);
		bus_write(`OFS_FRAC_DIV, 32'h00000003);
		bus_write(`OFS_FRAC, 32'h00000009);
		base = n_f;
		tick(4, 9);
		check("frac pulses", n_f - base, 3);
		bus_write(`OFS_FRAC, 32'h00000008);
		base = n_f;
		tick(4, 6);
		check("frac off", n_f - base, 0);
		$display("test prescalers done");
	endtask : test_prescalers

	// ----------------------------------------
	// end of run
	// ----------------------------------------
	task automatic conclude();
		$display("checks %0d mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : conclude

	// main sequence
	initial begin
		repeat (2) @(posedge clk);
		reset <= 1'b0;
		test_reset_and_lock();
		test_backup();
		test_gclk();
		test_pll();
		test_prescalers();
		conclude();
	end

	// watchdog well beyond the expected run length
	initial begin
		repeat (20000) @(posedge clk);
		err_total++;
		conclude();
	end

endmodule : tb_system_clock_config_regs
